// file: rtl/bsadc_pkg.sv
// package for the battery converter result control block
// assumes a single 20 MHz system clock domain
package bsadc_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned RES_W = 16;
  localparam int unsigned ACC_W = 32;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned RATE_W = 16;
  // rate limits in hertz
  localparam int unsigned NORM_MIN_HZ = 4;
  localparam int unsigned NORM_MAX_HZ = 8000;
  localparam int unsigned LP_MIN_HZ = 1;
  localparam int unsigned LP_MAX_HZ = 2000;
  // settling conversion counts
  localparam logic [1:0] SETTLE_NOCHOP = 2'h3;
  localparam logic [1:0] SETTLE_CHOP = 2'h2;
  // cycles per conversion at the shortest documented period
  localparam int unsigned MIN_PERIOD_CYC = CLK_HZ / NORM_MAX_HZ;
  localparam int unsigned LP_MIN_PERIOD_CYC = CLK_HZ / LP_MAX_HZ;
  // over-range threshold on a run of identical raw modulator bits
  localparam logic [3:0] ORNG_WIN = 4'hf;
  // setup and operating register bit positions
  localparam int unsigned GSW_CONNECT_BIT = 7;
  localparam int unsigned GSW_RES_BIT = 6;
  localparam int unsigned ATTEN_BIT = 7;

  typedef enum logic [1:0] {
    BSADC_SRC_VBAT = 2'b00,
    BSADC_SRC_EXT_TEMP = 2'b01,
    BSADC_SRC_INT_TEMP = 2'b10
  } bsadc_src_t;

  typedef enum logic [1:0] {
    BSADC_GSW_FLOAT = 2'b00,
    BSADC_GSW_DIRECT = 2'b01,
    BSADC_GSW_RES = 2'b10
  } bsadc_gsw_t;

  // one channel result with its qualifiers
  typedef struct packed {
    logic valid;
    logic settled;
    logic [RES_W-1:0] data;
  } bsadc_res_t;
endpackage : bsadc_pkg

// file: rtl/bsadc_ctrl.sv
// two-channel sigma-delta decimation and result control
// assumes modulator bit streams synchronous to clk, one bit per clock
`timescale 1ns/1ps
// Notes on behaviour
// - current rate programmable, normal and low power
// - sinc3 decimation gives 16-bit results
// - conversion counter raises event at limit
// - result above threshold raises event
// - accumulator sums results when enabled
// - enabled fast over-range flag precedes filter
// - current settles after three, chop two
// - voltage channel input from three sources
// - voltage channel uses same decimation scheme
// - input switch settles after three conversions
// - ground switch floats when connect bit clear
// - connect set: direct or via resistor
module bsadc_ctrl #(
  parameter int unsigned DEC_W = bsadc_pkg::RATE_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // modulator streams
  input wire logic i_mod_bit,
  input wire logic vt_mod_bit,
  // current channel control
  input wire logic i_enable,
  input wire logic low_power,
  input wire logic chop_en,
  input wire logic [DEC_W-1:0] i_decim,
  input wire logic [bsadc_pkg::CNT_W-1:0] count_limit,
  input wire logic [bsadc_pkg::RES_W-1:0] threshold,
  input wire logic acc_enable,
  input wire logic acc_clear,
  input wire logic orng_enable,
  // voltage channel control
  input wire logic vt_enable,
  input wire logic [DEC_W-1:0] vt_decim,
  input wire bsadc_pkg::bsadc_src_t vt_src,
  input wire logic [7:0] high_voltage_setup_register,
  input wire logic [7:0] converter_setup_register,
  input wire logic [7:0] converter_operating_register,
  // results and events
  output bsadc_pkg::bsadc_res_t i_result,
  output bsadc_pkg::bsadc_res_t vt_result,
  output logic [bsadc_pkg::ACC_W-1:0] i_accum,
  output logic [bsadc_pkg::CNT_W-1:0] i_count,
  output logic count_event,
  output logic thresh_event,
  output logic orng_event,
  // analog controls
  output bsadc_pkg::bsadc_src_t vt_mux_sel,
  output logic atten_en,
  output bsadc_pkg::bsadc_gsw_t ground_switch_pin
);
  import bsadc_pkg::*;

  // per-channel sinc3 state: index 0 current, 1 voltage/temperature
  logic [1:0] ch_en;
  logic [1:0] ch_bit;
  logic [DEC_W-1:0] ch_dec [2];
  logic [1:0] ch_restart;
  logic [ACC_W-1:0] int1_q [2], int1_d [2];
  logic [ACC_W-1:0] int2_q [2], int2_d [2];
  logic [ACC_W-1:0] int3_q [2], int3_d [2];
  logic [ACC_W-1:0] dif1_q [2], dif1_d [2];
  logic [ACC_W-1:0] dif2_q [2], dif2_d [2];
  logic [ACC_W-1:0] dif3_q [2], dif3_d [2];
  logic [DEC_W-1:0] phase_q [2], phase_d [2];
  logic [1:0] settle_q [2], settle_d [2];
  bsadc_res_t res_q [2], res_d [2];
  bsadc_src_t src_q;
  bsadc_src_t src_d;
  logic [DEC_W-1:0] i_dec_lim;
  logic [DEC_W-1:0] lp_floor;

  // low power enforces a longer minimum period
  // floor is the 2 kHz period, held as cycles minus one
  assign lp_floor = DEC_W'(LP_MIN_PERIOD_CYC - 1);
  always_comb begin
    i_dec_lim = i_decim;
    if (low_power && (i_decim < lp_floor)) begin
      i_dec_lim = lp_floor;
    end
  end

  assign ch_en = {vt_enable, i_enable};
  assign ch_bit = {vt_mod_bit, i_mod_bit};
  assign ch_dec[0] = i_dec_lim;
  assign ch_dec[1] = vt_decim;
  // channel switch restarts voltage settling
  // compare the legalised source so that code 3 does not restart forever
  assign ch_restart = {(src_d != src_q), 1'b0};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      logic [ACC_W-1:0] c3, o1, o2, o3;
      logic [1:0] need;
      // sinc3 integrate, then comb at each decimation tick
      always_comb begin
        need = (g == 0 && chop_en) ? SETTLE_CHOP : SETTLE_NOCHOP;
        int1_d[g] = int1_q[g] + {{(ACC_W-1){1'b0}}, ch_bit[g]};
        int2_d[g] = int2_q[g] + int1_q[g];
        int3_d[g] = int3_q[g] + int2_q[g];
        phase_d[g] = phase_q[g] + {{(DEC_W-1){1'b0}}, 1'b1};
        dif1_d[g] = dif1_q[g];
        dif2_d[g] = dif2_q[g];
        dif3_d[g] = dif3_q[g];
        settle_d[g] = settle_q[g];
        res_d[g] = res_q[g];
        res_d[g].valid = 1'b0;
        c3 = int3_q[g];
        o1 = c3 - dif1_q[g];
        o2 = o1 - dif2_q[g];
        o3 = o2 - dif3_q[g];
        if (!ch_en[g] || ch_restart[g]) begin
          settle_d[g] = 2'h0;
          phase_d[g] = '0;
          res_d[g].settled = 1'b0;
        end else if (phase_q[g] >= ch_dec[g]) begin
          phase_d[g] = '0;
          dif1_d[g] = c3;
          dif2_d[g] = o1;
          dif3_d[g] = o2;
          if (settle_q[g] < need) begin
            settle_d[g] = settle_q[g] + 2'h1;
          end
          res_d[g].valid = 1'b1;
          // widened so a saturated count does not wrap to unsettled
          res_d[g].settled =
            ({1'b0, settle_q[g]} + 3'h1) >= {1'b0, need};
          res_d[g].data = o3[RES_W-1:0];
        end
      end
      // register sinc3 state
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          int1_q[g] <= '0;
          int2_q[g] <= '0;
          int3_q[g] <= '0;
          dif1_q[g] <= '0;
          dif2_q[g] <= '0;
          dif3_q[g] <= '0;
          phase_q[g] <= '0;
          settle_q[g] <= 2'h0;
          res_q[g] <= '0;
        end else begin
          int1_q[g] <= int1_d[g];
          int2_q[g] <= int2_d[g];
          int3_q[g] <= int3_d[g];
          dif1_q[g] <= dif1_d[g];
          dif2_q[g] <= dif2_d[g];
          dif3_q[g] <= dif3_d[g];
          phase_q[g] <= phase_d[g];
          settle_q[g] <= settle_d[g];
          res_q[g] <= res_d[g];
        end
      end
    end
  endgenerate

  assign i_result = res_q[0];
  assign vt_result = res_q[1];

  // current channel counter, threshold, accumulator
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [ACC_W-1:0] acc_q, acc_d;
  logic cev_q, cev_d, tev_q, tev_d;
  logic i_done;
  assign i_done = res_q[0].valid && res_q[0].settled;
  always_comb begin
    cnt_d = cnt_q;
    acc_d = acc_q;
    cev_d = 1'b0;
    tev_d = 1'b0;
    if (acc_clear) begin
      acc_d = '0;
    end
    if (i_done) begin
      if (cnt_q + 1'b1 >= count_limit) begin
        cnt_d = '0;
        cev_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
      tev_d = res_q[0].data > threshold;
      if (acc_enable) begin
        acc_d = acc_d + {{(ACC_W-RES_W){1'b0}}, res_q[0].data};
      end
    end
  end
  // register current channel bookkeeping
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
      acc_q <= '0;
      cev_q <= 1'b0;
      tev_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      acc_q <= acc_d;
      cev_q <= cev_d;
      tev_q <= tev_d;
    end
  end
  assign i_accum = acc_q;
  assign i_count = cnt_q;
  assign count_event = cev_q;
  assign thresh_event = tev_q;

  // fast over-range: a run of identical modulator bits
  logic [3:0] run_q, run_d;
  logic last_q, last_d, orng_q, orng_d;
  always_comb begin
    last_d = i_mod_bit;
    run_d = (i_mod_bit == last_q) ? run_q : 4'h0;
    if (i_mod_bit == last_q && run_q != ORNG_WIN) begin
      run_d = run_q + 4'h1;
    end
    orng_d = orng_enable && i_enable && (run_q == ORNG_WIN);
  end
  // register over-range detector
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= 4'h0;
      last_q <= 1'b0;
      orng_q <= 1'b0;
    end else begin
      run_q <= run_d;
      last_q <= last_d;
      orng_q <= orng_d;
    end
  end
  assign orng_event = orng_q;

  // input mux, attenuator, ground switch
  bsadc_gsw_t gsw_d, gsw_q;
  logic att_d, att_q;
  always_comb begin
    src_d = (vt_src == BSADC_SRC_EXT_TEMP || vt_src == BSADC_SRC_INT_TEMP)
      ? vt_src : BSADC_SRC_VBAT;
    att_d = high_voltage_setup_register[ATTEN_BIT];
    if (!converter_setup_register[GSW_CONNECT_BIT]) begin
      gsw_d = BSADC_GSW_FLOAT;
    end else if (converter_operating_register[GSW_RES_BIT]) begin
      gsw_d = BSADC_GSW_RES;
    end else begin
      gsw_d = BSADC_GSW_DIRECT;
    end
  end
  // register analog controls
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      src_q <= BSADC_SRC_VBAT;
      att_q <= 1'b0;
      gsw_q <= BSADC_GSW_FLOAT;
    end else begin
      src_q <= src_d;
      att_q <= att_d;
      gsw_q <= gsw_d;
    end
  end
  assign vt_mux_sel = src_q;
  assign atten_en = att_q;
  assign ground_switch_pin = gsw_q;

  a_gsw_float: assert property (@(posedge clk) disable iff (!reset_n)
    !converter_setup_register[GSW_CONNECT_BIT]
    |=> ground_switch_pin == BSADC_GSW_FLOAT)
    else $error("ground switch not floating");
  a_gsw_res: assert property (@(posedge clk) disable iff (!reset_n)
    converter_setup_register[GSW_CONNECT_BIT]
    && converter_operating_register[GSW_RES_BIT]
    |=> ground_switch_pin == BSADC_GSW_RES)
    else $error("ground switch not via resistor");
  a_gsw_direct: assert property (@(posedge clk) disable iff (!reset_n)
    converter_setup_register[GSW_CONNECT_BIT]
    && !converter_operating_register[GSW_RES_BIT]
    |=> ground_switch_pin == BSADC_GSW_DIRECT)
    else $error("ground switch not direct");
  a_thresh_evt: assert property (@(posedge clk) disable iff (!reset_n)
    i_done && res_q[0].data > threshold |=> thresh_event)
    else $error("threshold event missing");
  a_acc_add: assert property (@(posedge clk) disable iff (!reset_n)
    i_done && acc_enable && !acc_clear
    |=> i_accum == $past(i_accum) + {16'h0000, $past(res_q[0].data)})
    else $error("accumulator did not add");
  a_vt_switch: assert property (@(posedge clk) disable iff (!reset_n)
    src_d != src_q |=> !vt_result.valid)
    else $error("result after channel switch");
  a_orng_gate: assert property (@(posedge clk) disable iff (!reset_n)
    !orng_enable |=> !orng_event)
    else $error("over-range while disabled");
  a_cnt_evt: assert property (@(posedge clk) disable iff (!reset_n)
    count_event |-> i_count == 16'h0000)
    else $error("count not reset on event");
  a_settle_first: assert property (@(posedge clk) disable iff (!reset_n)
    i_result.valid && i_result.settled && !chop_en |-> settle_q[0] == 2'h3)
    else $error("settled too early");
  a_vt_settled: assert property (@(posedge clk) disable iff (!reset_n)
    vt_result.valid && settle_q[1] == SETTLE_NOCHOP |-> vt_result.settled)
    else $error("settled flag lost");
  a_mux_legal: assert property (@(posedge clk) disable iff (!reset_n)
    vt_mux_sel != 2'b11)
    else $error("illegal input select");
endmodule : bsadc_ctrl

// file: verification/bsadc_sensor_model.sv
// far-side model: shunt, battery and temperature sensor modulators
// assumes one modulator bit per rising clk edge
`timescale 1ns/1ps
module bsadc_sensor_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // overload request from the bench
  input wire logic stuck,
  // modulator streams
  output logic i_bit,
  output logic vt_bit
);
  logic [1:0] ph_q;
  // free-running phase gives a fixed duty pattern
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_q <= 2'h0;
    end else begin
      ph_q <= ph_q + 2'h1;
    end
  end
  // stuck input drives a solid run of ones to provoke overload
  assign i_bit = stuck | (ph_q != 2'h0);
  assign vt_bit = ph_q[0];
endmodule : bsadc_sensor_model

// file: verification/testbench.sv
// self-checking bench for the converter result control block
// assumes the sensor model as far side and a 20 MHz clock
`timescale 1ns/1ps
module testbench;
  import bsadc_pkg::*;
  logic clk = 0, reset_n = 0, stuck = 0, i_mod_bit, vt_mod_bit;
  logic i_enable = 0, low_power = 0, chop_en = 0, vt_enable = 0;
  logic acc_enable = 0, acc_clear = 0, orng_enable = 0;
  logic [15:0] i_decim = 16'h0009, vt_decim = 16'h0009;
  logic [15:0] count_limit = 16'h0002, threshold = 16'h0000;
  logic [7:0] hv_reg = 8'h00, cfg_reg = 8'h00, op_reg = 8'h00;
  bsadc_src_t vt_src = BSADC_SRC_VBAT, vt_mux_sel;
  bsadc_res_t i_result, vt_result;
  bsadc_gsw_t ground_switch_pin;
  logic [31:0] i_accum, acc_exp;
  logic [15:0] i_count;
  logic count_event, thresh_event, orng_event, atten_en, s;
  int miscompares = 0, n_checks = 0, n, ev;
  bsadc_ctrl dut_u (.clk(clk), .reset_n(reset_n), .i_mod_bit(i_mod_bit),
    .vt_mod_bit(vt_mod_bit), .i_enable(i_enable), .low_power(low_power),
    .chop_en(chop_en), .i_decim(i_decim), .count_limit(count_limit),
    .threshold(threshold), .acc_enable(acc_enable), .acc_clear(acc_clear),
    .orng_enable(orng_enable), .vt_enable(vt_enable), .vt_decim(vt_decim),
    .vt_src(vt_src), .high_voltage_setup_register(hv_reg),
    .converter_setup_register(cfg_reg),
    .converter_operating_register(op_reg), .i_result(i_result),
    .vt_result(vt_result), .i_accum(i_accum), .i_count(i_count),
    .count_event(count_event), .thresh_event(thresh_event),
    .orng_event(orng_event), .vt_mux_sel(vt_mux_sel), .atten_en(atten_en),
    .ground_switch_pin(ground_switch_pin));
  bsadc_sensor_model model_u (.clk(clk), .reset_n(reset_n), .stuck(stuck),
    .i_bit(i_mod_bit), .vt_bit(vt_mod_bit));
  initial begin
    forever #25 clk = ~clk;
  end
  // compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task give_verdict;
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // wait for the next result pulse, bounded; leaves 1 ns after the edge
  task wait_res(input bit vt);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (!((vt ? vt_result.valid : i_result.valid) === 1'b1)
      && n < 12000);
    s = vt ? vt_result.settled : i_result.settled;
    if (n >= 12000) check(32'h0, 32'h1);
  endtask : wait_res
  // settled flag rises on the nconv-th result and stays on the next
  task settle(input bit vt, input int nconv);
    for (int k = 1; k <= nconv + 1; k++) begin
      wait_res(vt);
      check(s, k >= nconv);
      if (k > 1) check(n, 10);
    end
    #4;
  endtask : settle
  // one cycle step, then check at 1 ns
  task step;
    @(posedge clk);
    #1;
  endtask : step
  initial begin
    #(50 * 40000);
    miscompares++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    #5 reset_n = 1;
    check(ground_switch_pin, 0);
    check(vt_mux_sel, 0);
    check(i_result, 0);
    // ground switch table over all four combinations
    for (int k = 0; k < 4; k++) begin
      cfg_reg[7] = k[1];
      op_reg[6] = k[0];
      step();
      check(ground_switch_pin, k < 2 ? 0 : k - 1);
      #4;
    end
    // attenuator set before measuring the battery
    hv_reg = 8'h80;
    step();
    check(atten_en, 1);
    #4;
    for (int k = 0; k < 4; k++) begin
      vt_src = bsadc_src_t'(k);
      step();
      check(vt_mux_sel, k % 3);
      #4;
    end
    vt_src = BSADC_SRC_VBAT;
    vt_enable = 1;
    settle(1, 3);
    vt_src = BSADC_SRC_INT_TEMP;
    settle(1, 3);
    i_enable = 1;
    settle(0, 3);
    i_enable = 0;
    chop_en = 1;
    @(posedge clk);
    #5 i_enable = 1;
    settle(0, 2);
    // clear between results, then accumulate, count and compare
    // let the last settled result be booked before enabling the sum
    step();
    #4;
    acc_clear = 1;
    acc_enable = 1;
    acc_exp = 0;
    ev = 0;
    @(posedge clk);
    #5 acc_clear = 0;
    for (int k = 0; k < 4; k++) begin
      wait_res(0);
      acc_exp += {16'h0, i_result.data};
      step();
      check(thresh_event, i_result.data > threshold);
      check(i_count, (k + 1) % 2);
      ev += count_event;
      #4 threshold = {16{k[0]}};
    end
    check(ev, 2);
    check(i_accum, acc_exp);
    // solid ones: no over-range while disabled, one once enabled
    stuck = 1;
    for (int p = 0; p < 2; p++) begin
      ev = 0;
      repeat (40) begin
        step();
        ev |= orng_event;
      end
      check(ev, p);
      #4 orng_enable = 1;
    end
    stuck = 0;
    low_power = 1;
    i_enable = 0;
    @(posedge clk);
    #5 i_enable = 1;
    wait_res(0);
    wait_res(0);
    check(n, LP_MIN_PERIOD_CYC);
    give_verdict();
  end
endmodule : testbench
